// ### rtl/gpm_defines.svh
// constants of the general purpose pin port: offsets, fields, reset values, counts
`ifndef GPM_DEFINES_SVH
`define GPM_DEFINES_SVH

`define GPM_NPIN 5
`define GPM_FIFO_DEPTH 64
`define GPM_DATA_W 8
`define GPM_ADDR_W 6
`define GPM_NCOEX 3

// register byte offsets
`define GPM_OFF_DIR 6'h00
`define GPM_OFF_OUT 6'h04
`define GPM_OFF_IN 6'h08
`define GPM_OFF_PEN 6'h0c
`define GPM_OFF_PSEL 6'h10
`define GPM_OFF_FN 6'h14
`define GPM_OFF_STRAP 6'h18
`define GPM_OFF_DATA 6'h1c
`define GPM_OFF_STAT 6'h20
`define GPM_OFF_DIV 6'h24

// function register fields and reset
`define GPM_FN_FREQ 0
`define GPM_FN_COEX 1
`define GPM_FN_UART 4
`define GPM_FN_W 5
`define GPM_FN_RESET 5'h0e

// status register fields
`define GPM_ST_DR 0
`define GPM_ST_OVR 1
`define GPM_ST_TXNF 5
`define GPM_ST_TXE 6

// pin slots: slot 1 is pin 1, slots 2..4 are pins 2..4
`define GPM_SLOT_FREQ 1
`define GPM_SLOT_COEX 2

`define GPM_DIV_W 16
`define GPM_DIV_RESET 16'h0364
`define GPM_STRAP_WAIT 2'h3
`define GPM_FRAME_BITS 4'h9
`define GPM_LAST_DATA 4'h7

`endif

// ### rtl/gpm_pkg.sv
// types shared by the pin port files
`include "gpm_defines.svh"
package gpm_pkg;

    // avalon request from the master
    typedef struct packed {
        logic read;
        logic write;
        logic [`GPM_ADDR_W-1:0] address;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } gpm_av_req_type;

    // pad control towards the pin cells
    typedef struct packed {
        logic [`GPM_NPIN-1:0] o;
        logic [`GPM_NPIN-1:0] oe;
        logic [`GPM_NPIN-1:0] pull_up;
        logic [`GPM_NPIN-1:0] pull_dn;
    } gpm_pad_type;

    // serial transmitter states
    typedef enum logic [1:0] {
        GPM_TX_IDLE = 2'b01,
        GPM_TX_SHIFT = 2'b10
    } gpm_tx_type;

    // serial receiver states
    typedef enum logic [3:0] {
        GPM_RX_IDLE = 4'b0001,
        GPM_RX_START = 4'b0010,
        GPM_RX_DATA = 4'b0100,
        GPM_RX_STOP = 4'b1000
    } gpm_rx_type;

endpackage

// ### rtl/gpm_fifo_mem.sv
// small two-port memory holding serial buffer entries, registered read
`timescale 1ns/1ps
module gpm_fifo_mem #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 64
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // write port
    input wire logic we,
    input wire logic [$clog2(DEPTH)-1:0] waddr,
    input wire logic [WIDTH-1:0] wdata,
    // read port
    input wire logic [$clog2(DEPTH)-1:0] raddr,
    output logic [WIDTH-1:0] rdata_q
);
    logic [WIDTH-1:0] mem [DEPTH]; // storage, no reset needed

    // write side
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // read data registered; a same-edge write shows one edge later
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= mem[raddr];
        end
    end
endmodule // gpm_fifo_mem

// ### rtl/gpm_top.sv
// general purpose pin port with coexistence muxing, strap and debug serial port
//
// The Avalon-MM register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "gpm_defines.svh"
module gpm_top #(
    parameter int NPIN = `GPM_NPIN,
    parameter int DEPTH = `GPM_FIFO_DEPTH,
    parameter int DATA_W = `GPM_DATA_W
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // avalon register bus
    input gpm_pkg::gpm_av_req_type av_req,
    output logic [31:0] av_readdata,
    output logic av_waitrequest,
    // general purpose pads
    input wire logic [NPIN-1:0] gpio_i,
    output gpm_pkg::gpm_pad_type gpio_pad,
    // coexistence logic side
    input wire logic [`GPM_NCOEX-1:0] coex_o,
    input wire logic [`GPM_NCOEX-1:0] coex_oe,
    output logic [`GPM_NCOEX-1:0] coex_i,
    input wire logic coex_freq,
    // scan data pads and scan logic side
    input wire logic tdi_pin,
    output logic tdo_pin_o,
    output logic tdo_pin_oe,
    output logic scan_tdi,
    input wire logic scan_tdo,
    input wire logic scan_tdo_oe,
    // strap result
    output logic host_if_sel
);
    import gpm_pkg::*;

    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

    // parameters the logic cannot serve
    if (NPIN != `GPM_NPIN || DATA_W != `GPM_DATA_W || DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad
        $error("gpm_top: unsupported parameter values");
    end

    // all state of the block except the buffer memories
    typedef struct packed {
        logic wait_n;                    // high while no answer is pending
        logic [31:0] rdata;
        logic [NPIN-1:0] dir;            // 1 drives the pin
        logic [NPIN-1:0] dout;
        logic [NPIN-1:0] pen;            // pull enable
        logic [NPIN-1:0] psel;           // 1 pull-up, 0 pull-down
        logic [`GPM_FN_W-1:0] fn;
        logic [`GPM_DIV_W-1:0] div;
        logic [1:0] strap_cnt;
        logic strap_done;
        logic host_sel;
        gpm_pad_type pad;
        logic [`GPM_NCOEX-1:0] coex_in;
        logic scan_in;
        logic tdo_o;
        logic tdo_oe;
        logic [NPIN-1:0] gs1;            // pin synchroniser stages
        logic [NPIN-1:0] gs2;
        logic ts1;
        logic ts2;
        logic [AW-1:0] tx_wp;
        logic [AW-1:0] tx_rp;
        logic [AW:0] tx_n;
        logic [AW-1:0] rx_wp;
        logic [AW-1:0] rx_rp;
        logic [AW:0] rx_n;
        logic rx_rdy;                    // head entry readable
        logic tx_nempty;                 // head entry readable
        logic ovr;
        gpm_tx_type tx_st;
        logic [`GPM_DIV_W-1:0] tx_cnt;
        logic [3:0] tx_bit;
        logic [9:0] tx_sh;
        gpm_rx_type rx_st;
        logic [`GPM_DIV_W-1:0] rx_cnt;
        logic [3:0] rx_bit;
        logic [DATA_W-1:0] rx_sh;
        logic rx_prev;
    } gpm_state_type;

    gpm_state_type q; // registered state
    gpm_state_type s; // next state

    logic [DATA_W-1:0] tx_rdata; // head of transmit buffer
    logic [DATA_W-1:0] rx_rdata; // head of receive buffer
    logic tx_push;
    logic tx_pop;
    logic rx_push;
    logic rx_pop;
    logic [DATA_W-1:0] tx_wdata;
    logic [NPIN-1:0] pad_o_d;
    logic [NPIN-1:0] pad_oe_d;

    // register read decode, shared by read answer and byte merge
    function automatic logic [31:0] rd_mux(input gpm_state_type st, input logic [`GPM_ADDR_W-1:0] a,
                                           input logic [DATA_W-1:0] rxd);
        logic [31:0] v;
        v = '0;
        case (a)
            `GPM_OFF_DIR: v[NPIN-1:0] = st.dir;
            `GPM_OFF_OUT: v[NPIN-1:0] = st.dout;
            `GPM_OFF_IN: v[NPIN-1:0] = st.gs2;
            `GPM_OFF_PEN: v[NPIN-1:0] = st.pen;
            `GPM_OFF_PSEL: v[NPIN-1:0] = st.psel;
            `GPM_OFF_FN: v[`GPM_FN_W-1:0] = st.fn;
            `GPM_OFF_STRAP: v[0] = st.host_sel;
            `GPM_OFF_DATA: v[DATA_W-1:0] = st.rx_rdy ? rxd : '0;
            `GPM_OFF_STAT: begin
                v[`GPM_ST_DR] = st.rx_rdy;
                v[`GPM_ST_OVR] = st.ovr;
                v[`GPM_ST_TXNF] = (st.tx_n != FULL);
                v[`GPM_ST_TXE] = (st.tx_n == '0) && (st.tx_st == GPM_TX_IDLE);
            end
            `GPM_OFF_DIV: v[`GPM_DIV_W-1:0] = st.div;
            default: v = '0; // unmapped reads as zero
        endcase
        return v;
    endfunction

    // per pin function select: coexistence or frequency owner, else plain pin
    for (genvar i = 0; i < NPIN; i++) begin : g_pin
        if (i == `GPM_SLOT_FREQ) begin : g_freq
            assign pad_o_d[i] = q.fn[`GPM_FN_FREQ] ? coex_freq : q.dout[i];
            assign pad_oe_d[i] = q.fn[`GPM_FN_FREQ] ? 1'b1 : q.dir[i];
        end else if (i >= `GPM_SLOT_COEX) begin : g_coex
            assign pad_o_d[i] = q.fn[`GPM_FN_COEX+i-2] ? coex_o[i-2] : q.dout[i];
            assign pad_oe_d[i] = q.fn[`GPM_FN_COEX+i-2] ? coex_oe[i-2] : q.dir[i];
        end else begin : g_plain
            assign pad_o_d[i] = q.dout[i];
            assign pad_oe_d[i] = q.dir[i] & q.strap_done;
        end
    end

    // next state of everything
    always_comb begin
        logic acc;
        logic [31:0] w;
        logic line;
        s = q;
        acc = 1'b0;
        w = '0;
        line = 1'b1;
        tx_push = 1'b0;
        tx_pop = 1'b0;
        rx_push = 1'b0;
        rx_pop = 1'b0;
        tx_wdata = '0;
        // pins from outside pass two flops
        s.gs1 = gpio_i;
        s.gs2 = q.gs1;
        s.ts1 = tdi_pin;
        s.ts2 = q.ts1;
        // strap caught once the synchroniser holds a real pin level
        if (!q.strap_done) begin
            s.strap_cnt = q.strap_cnt + 2'h1;
            if (q.strap_cnt == `GPM_STRAP_WAIT) begin
                s.strap_done = 1'b1;
                s.host_sel = q.gs2[0];
            end
        end
        // bus: answer prepared on first edge, access done on the waitrequest-low edge
        s.wait_n = 1'b1;
        if ((av_req.read || av_req.write) && q.wait_n) begin
            s.wait_n = 1'b0;
            s.rdata = rd_mux(q, av_req.address, rx_rdata);
        end
        acc = (av_req.read || av_req.write) && !q.wait_n;
        if (acc && av_req.write) begin
            w = rd_mux(q, av_req.address, rx_rdata);
            for (int b = 0; b < 4; b++) begin
                if (av_req.byteenable[b]) begin
                    w[b*8 +: 8] = av_req.writedata[b*8 +: 8];
                end
            end
            case (av_req.address)
                `GPM_OFF_DIR: s.dir = w[NPIN-1:0];
                `GPM_OFF_OUT: s.dout = w[NPIN-1:0];
                `GPM_OFF_PEN: s.pen = w[NPIN-1:0];
                `GPM_OFF_PSEL: s.psel = w[NPIN-1:0];
                `GPM_OFF_FN: s.fn = w[`GPM_FN_W-1:0];
                `GPM_OFF_DIV: s.div = w[`GPM_DIV_W-1:0];
                `GPM_OFF_DATA: begin
                    tx_push = av_req.byteenable[0] && (q.tx_n != FULL); // full buffer drops the byte
                    tx_wdata = av_req.writedata[DATA_W-1:0];
                end
                default: ; // read-only or unmapped
            endcase
        end
        if (acc && av_req.read) begin
            if (av_req.address == `GPM_OFF_DATA) begin
                rx_pop = q.rx_rdy;
            end
            if (av_req.address == `GPM_OFF_STAT) begin
                s.ovr = 1'b0; // cleared by status read, set below wins
            end
        end
        // transmitter, 8 data bits, no parity, one stop
        case (q.tx_st)
            GPM_TX_IDLE: begin
                if (q.tx_nempty && q.fn[`GPM_FN_UART]) begin
                    tx_pop = 1'b1;
                    s.tx_sh = {1'b1, tx_rdata, 1'b0};
                    s.tx_cnt = q.div;
                    s.tx_bit = '0;
                    s.tx_st = GPM_TX_SHIFT;
                end
            end
            GPM_TX_SHIFT: begin
                s.tx_cnt = q.tx_cnt - 1'b1;
                if (q.tx_cnt == '0) begin
                    s.tx_cnt = q.div;
                    s.tx_sh = {1'b1, q.tx_sh[9:1]};
                    s.tx_bit = q.tx_bit + 4'h1;
                    if (q.tx_bit == `GPM_FRAME_BITS) begin
                        s.tx_st = GPM_TX_IDLE;
                    end
                end
            end
            default: s.tx_st = GPM_TX_IDLE;
        endcase
        // receiver sees an idle line while the port is off
        line = q.fn[`GPM_FN_UART] ? q.ts2 : 1'b1;
        s.rx_prev = line;
        case (q.rx_st)
            GPM_RX_IDLE: begin
                if (q.rx_prev && !line) begin
                    s.rx_cnt = q.div >> 1;
                    s.rx_st = GPM_RX_START;
                end
            end
            GPM_RX_START: begin
                s.rx_cnt = q.rx_cnt - 1'b1;
                if (q.rx_cnt == '0) begin
                    s.rx_cnt = q.div;
                    s.rx_bit = '0;
                    s.rx_st = line ? GPM_RX_IDLE : GPM_RX_DATA; // glitch rejected
                end
            end
            GPM_RX_DATA: begin
                s.rx_cnt = q.rx_cnt - 1'b1;
                if (q.rx_cnt == '0) begin
                    s.rx_cnt = q.div;
                    s.rx_sh = {line, q.rx_sh[DATA_W-1:1]};
                    s.rx_bit = q.rx_bit + 4'h1;
                    if (q.rx_bit == `GPM_LAST_DATA) begin
                        s.rx_st = GPM_RX_STOP;
                    end
                end
            end
            GPM_RX_STOP: begin
                s.rx_cnt = q.rx_cnt - 1'b1;
                if (q.rx_cnt == '0) begin
                    s.rx_st = GPM_RX_IDLE;
                    if (line) begin
                        rx_push = (q.rx_n != FULL);
                        if (q.rx_n == FULL) begin
                            s.ovr = 1'b1; // byte lost, flag set wins over clear
                        end
                    end
                end
            end
            default: s.rx_st = GPM_RX_IDLE;
        endcase
        // buffer pointers; readable flags lag a push or pop by one edge
        s.tx_wp = q.tx_wp + AW'(tx_push);
        s.tx_rp = q.tx_rp + AW'(tx_pop);
        s.tx_n = q.tx_n + (AW+1)'(tx_push) - (AW+1)'(tx_pop);
        s.tx_nempty = (q.tx_n != '0) && !tx_pop;
        s.rx_wp = q.rx_wp + AW'(rx_push);
        s.rx_rp = q.rx_rp + AW'(rx_pop);
        s.rx_n = q.rx_n + (AW+1)'(rx_push) - (AW+1)'(rx_pop);
        s.rx_rdy = (q.rx_n != '0) && !rx_pop;
        // pads and muxed pins
        s.pad.o = pad_o_d;
        s.pad.oe = pad_oe_d;
        s.pad.pull_up = q.pen & q.psel;
        s.pad.pull_dn = q.pen & ~q.psel;
        s.coex_in = q.gs2[NPIN-1:`GPM_SLOT_COEX] & q.fn[`GPM_FN_COEX +: `GPM_NCOEX];
        // scan data pins belong to scan unless the serial port owns them
        s.scan_in = q.fn[`GPM_FN_UART] ? 1'b1 : q.ts2;
        s.tdo_o = q.fn[`GPM_FN_UART] ? q.tx_sh[0] : scan_tdo;
        s.tdo_oe = q.fn[`GPM_FN_UART] ? 1'b1 : scan_tdo_oe;
    end

    // state register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            q <= '0;
            q.wait_n <= 1'b1;
            q.fn <= `GPM_FN_RESET;
            q.div <= `GPM_DIV_RESET;
            q.tx_sh <= '1;
            q.rx_prev <= 1'b1;
            q.tx_st <= GPM_TX_IDLE;
            q.rx_st <= GPM_RX_IDLE;
            q.tdo_oe <= 1'b0;
        end else begin
            q <= s;
        end
    end

    // transmit buffer
    gpm_fifo_mem #(.WIDTH(DATA_W), .DEPTH(DEPTH)) u_tx_mem (
        .clk(clk),
        .nrst(nrst),
        .we(tx_push),
        .waddr(q.tx_wp),
        .wdata(tx_wdata),
        .raddr(q.tx_rp),
        .rdata_q(tx_rdata)
    );

    // receive buffer
    gpm_fifo_mem #(.WIDTH(DATA_W), .DEPTH(DEPTH)) u_rx_mem (
        .clk(clk),
        .nrst(nrst),
        .we(rx_push),
        .waddr(q.rx_wp),
        .wdata(q.rx_sh),
        .raddr(q.rx_rp),
        .rdata_q(rx_rdata)
    );

    // outputs straight from flops
    assign av_readdata = q.rdata;
    assign av_waitrequest = q.wait_n;
    assign gpio_pad = q.pad;
    assign coex_i = q.coex_in;
    assign tdo_pin_o = q.tdo_o;
    assign tdo_pin_oe = q.tdo_oe;
    assign scan_tdi = q.scan_in;
    assign host_if_sel = q.host_sel;
endmodule // gpm_top

// ### dv/gpm_props.sv
// checker of the pin port behaviour, watching the top ports only
`timescale 1ns/1ps
`include "gpm_defines.svh"
module gpm_props #(
    parameter int NPIN = 5
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // register bus
    input gpm_pkg::gpm_av_req_type av_req,
    input wire logic av_waitrequest,
    // pads and mux sides
    input wire logic [NPIN-1:0] gpio_i,
    input gpm_pkg::gpm_pad_type gpio_pad,
    input wire logic [`GPM_NCOEX-1:0] coex_o,
    input wire logic [`GPM_NCOEX-1:0] coex_oe,
    input wire logic [`GPM_NCOEX-1:0] coex_i,
    input wire logic coex_freq,
    input wire logic tdo_pin_o,
    input wire logic tdo_pin_oe,
    input wire logic scan_tdi,
    input wire logic scan_tdo,
    input wire logic scan_tdo_oe,
    input wire logic host_if_sel
);
    import gpm_pkg::*;
    // shadow copies of the control registers, updated on accepted writes
    logic [4:0] dir_q, out_q, pen_q, psel_q, fn_q, pu_w, pd_w, fmask_w;
    logic [2:0] cmask_w; // coex-owned slots
    logic [15:0] div_q;
    logic [3:0] cnt_q; // edges since reset, saturating
    logic strap_q; // pin 0 level seen during the strap window
    assign pu_w = pen_q & psel_q;
    assign pd_w = pen_q & ~psel_q;
    assign cmask_w = fn_q[3:1];
    assign fmask_w = {fn_q[3:1], fn_q[0], 1'b0};
    // shadow registers follow the bus at the edge the write takes effect
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            {dir_q, out_q, pen_q, psel_q} <= 20'h0_0000;
            fn_q <= `GPM_FN_RESET;
            div_q <= `GPM_DIV_RESET;
            cnt_q <= 4'h0;
            strap_q <= 1'b0;
        end else begin
            cnt_q <= (cnt_q == 4'hf) ? cnt_q : cnt_q + 4'h1;
            strap_q <= (cnt_q == 4'h2) ? gpio_i[0] : strap_q;
            if (av_req.write && !av_waitrequest && av_req.byteenable[0]) begin
                case (av_req.address)
                    `GPM_OFF_DIR: dir_q <= av_req.writedata[4:0];
                    `GPM_OFF_OUT: out_q <= av_req.writedata[4:0];
                    `GPM_OFF_PEN: pen_q <= av_req.writedata[4:0];
                    `GPM_OFF_PSEL: psel_q <= av_req.writedata[4:0];
                    `GPM_OFF_FN: fn_q <= av_req.writedata[4:0];
                    `GPM_OFF_DIV: div_q <= av_req.writedata[15:0];
                    default: ;
                endcase
            end
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence s_req_taken;
        (av_req.read || av_req.write) && av_waitrequest;
    endsequence
    sequence s_start_bit;
        fn_q[4] && div_q == 16'h0004 && $fell(tdo_pin_o);
    endsequence
    chk_bus_one_wait: assert property (s_req_taken |=> !av_waitrequest ##1 av_waitrequest)
        else $error("waitrequest not low for exactly one cycle");
    chk_plain_tristate: assert property ((gpio_pad.oe & ~$past(dir_q) & ~$past(fmask_w)) == 5'h00)
        else $error("plain pin driven without direction set");
    chk_plain_drive: assert property ((cnt_q == 4'hf) |->
        ((gpio_pad.oe ^ $past(dir_q)) & ~$past(fmask_w)) == 5'h00 &&
        ((gpio_pad.o ^ $past(out_q)) & $past(dir_q & ~fmask_w)) == 5'h00)
        else $error("plain pin drive differs from registers");
    chk_pull_select: assert property ((cnt_q != 4'h0) |->
        gpio_pad.pull_up == $past(pu_w) && gpio_pad.pull_dn == $past(pd_w))
        else $error("pull controls differ from registers");
    chk_strap_hold: assert property ((cnt_q == 4'hf) |-> host_if_sel == strap_q)
        else $error("strap value not held");
    chk_coex_pass: assert property ((cnt_q != 4'h0) |->
        (((gpio_pad.oe[4:2] ^ $past(coex_oe)) | (gpio_pad.o[4:2] ^ $past(coex_o))) & $past(cmask_w)) == 3'h0)
        else $error("coex pin not following coex logic");
    chk_coex_in_zero: assert property ((coex_i & ~$past(cmask_w)) == 3'h0)
        else $error("coex input seen on plain pin");
    chk_freq_route: assert property ((cnt_q != 4'h0 && $past(fn_q[0])) |-> gpio_pad.o[1] == $past(coex_freq))
        else $error("frequency signal not on pin 1");
    chk_serial_owns: assert property ((cnt_q != 4'h0 && $past(fn_q[4])) |-> scan_tdi && tdo_pin_oe)
        else $error("serial port not owning scan pins");
    chk_scan_keep: assert property ((cnt_q != 4'h0 && !$past(fn_q[4])) |->
        tdo_pin_o == $past(scan_tdo) && tdo_pin_oe == $past(scan_tdo_oe))
        else $error("scan output disturbed while serial off");
    chk_bit_length: assert property (s_start_bit |=> (!tdo_pin_o) [*4])
        else $error("serial low bit shorter than divider");
endmodule // gpm_props

// ### dv/gpm_partner.sv
// parties on the pins: external drivers, pulls, serial loop plug
`timescale 1ns/1ps
module gpm_partner (
    // clock
    input wire logic clk,
    // pad control and outside drive
    input gpm_pkg::gpm_pad_type pad,
    input wire logic [4:0] ext_val,
    input wire logic [4:0] ext_oe,
    output logic [4:0] pin,
    // serial line
    input wire logic tdo_o,
    input wire logic tdo_oe,
    input wire logic loop_en,
    input wire logic ext_tdi,
    output logic tdi
);
    import gpm_pkg::*;
    logic float_q; // undriven pins wander instead of holding a value
    initial float_q = 1'b0;
    always_ff @(posedge clk) float_q <= ~float_q;
    // resolve each pin from all drivers, then pulls
    always_comb begin
        for (int k = 0; k < 5; k++) begin
            if (pad.oe[k]) pin[k] = pad.o[k];
            else if (ext_oe[k]) pin[k] = ext_val[k];
            else if (pad.pull_up[k] || pad.pull_dn[k]) pin[k] = pad.pull_up[k];
            else pin[k] = float_q ^ k[0];
        end
    end
    // loop plug returns transmit to receive; released line idles high
    assign tdi = loop_en ? (tdo_oe ? tdo_o : 1'b1) : ext_tdi;
endmodule // gpm_partner

// ### dv/tb_gpio_pin_function_mux.sv
// self-checking bench of the pin port: registers, muxing, strap, serial loop
`timescale 1ns/1ps
`include "gpm_defines.svh"
module tb_gpio_pin_function_mux;
    import gpm_pkg::*;
    logic clk, nrst, coex_freq, tdi_pin, tdo_pin_o, tdo_pin_oe, scan_tdi, scan_tdo, scan_tdo_oe, host_if_sel;
    logic av_waitrequest, loop_en, ext_tdi;
    logic [31:0] av_readdata, rd;
    logic [4:0] gpio_i, ext_val, ext_oe, dv, ev;
    logic [2:0] coex_o, coex_oe, coex_i;
    logic [15:0] lfsr_q; // stimulus source, fixed start
    logic [7:0] sent_q[$]; // bytes sent round the loop
    gpm_av_req_type av_req;
    gpm_pad_type gpio_pad;
    int error_cnt, n_checks, n;
    gpm_top #(.NPIN(5), .DEPTH(64), .DATA_W(8)) uut (.clk(clk), .nrst(nrst), .av_req(av_req),
        .av_readdata(av_readdata), .av_waitrequest(av_waitrequest), .gpio_i(gpio_i), .gpio_pad(gpio_pad),
        .coex_o(coex_o), .coex_oe(coex_oe), .coex_i(coex_i), .coex_freq(coex_freq), .tdi_pin(tdi_pin),
        .tdo_pin_o(tdo_pin_o), .tdo_pin_oe(tdo_pin_oe), .scan_tdi(scan_tdi), .scan_tdo(scan_tdo),
        .scan_tdo_oe(scan_tdo_oe), .host_if_sel(host_if_sel));
    gpm_partner u_part (.clk(clk), .pad(gpio_pad), .ext_val(ext_val), .ext_oe(ext_oe), .pin(gpio_i),
        .tdo_o(tdo_pin_o), .tdo_oe(tdo_pin_oe), .loop_en(loop_en), .ext_tdi(ext_tdi), .tdi(tdi_pin));
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // level read back: own drive wins, else the outside driver
    function automatic logic [4:0] exp_in(input logic [4:0] d, input logic [4:0] o, input logic [4:0] e);
        return (d & o) | (~d & e);
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    // one access, held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk);
        av_req <= '{read: !w, write: w, address: a, writedata: d, byteenable: 4'hf};
        do begin
            @(posedge clk);
            k++;
        end while (av_waitrequest !== 1'b0 && k < 100);
        if (k >= 100) error_cnt++;
        rd = av_readdata;
        av_req <= '0;
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // cut a hang short well past the expected run
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        wrap_up();
    end
    initial begin
        {nrst, coex_freq, scan_tdo, scan_tdo_oe, loop_en, ext_tdi} = 6'h01;
        {coex_o, coex_oe} = 6'h00;
        {ext_val, ext_oe} = 10'h021; // pin 0 strapped high
        av_req = '0;
        error_cnt = 0;
        n_checks = 0;
        lfsr_q = 16'h000c;
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        repeat (16) @(posedge clk);
        chk(32'(gpio_pad.oe[1:0]), 32'h0);
        chk(32'(host_if_sel), 32'h1);
        ext_val <= 5'h00;
        bus(1'b0, `GPM_OFF_FN, 32'h0);
        chk(rd, 32'h0000_000e);
        bus(1'b0, 6'h3c, 32'h0);
        chk(rd, 32'h0); // unmapped place reads zero
        bus(1'b0, `GPM_OFF_STRAP, 32'h0);
        chk(rd, 32'h1);
        $display("test reset done");
        // coex pins follow the coex logic by default
        for (int i = 0; i < 6; i++) begin
            lfsr_q = lfsr_next(lfsr_q);
            {coex_o, coex_oe} <= lfsr_q[5:0];
            repeat (5) @(posedge clk);
            chk(32'({gpio_pad.oe[4:2], gpio_pad.o[4:2] & coex_oe}), 32'({coex_oe, coex_o & coex_oe}));
            chk(32'({gpio_pad.o[1], gpio_pad.oe[1]}), 32'h0);
            chk(32'(coex_i & coex_oe), 32'(coex_o & coex_oe));
        end
        bus(1'b1, `GPM_OFF_FN, 32'h0000_0001);
        for (int i = 0; i < 4; i++) begin
            coex_freq <= i[0];
            repeat (3) @(posedge clk);
            chk(32'({gpio_pad.o[1], gpio_pad.oe[4:2]}), 32'({i[0], 3'h0}));
        end
        $display("test mux done");
        // plain pins in random directions against an outside driver
        bus(1'b1, `GPM_OFF_FN, 32'h0);
        for (int i = 0; i < 8; i++) begin
            lfsr_q = lfsr_next(lfsr_q);
            dv = (i == 0) ? 5'h1f : (i == 1) ? 5'h00 : lfsr_q[9:5];
            ext_val <= lfsr_q[4:0];
            ext_oe <= ~dv;
            bus(1'b1, `GPM_OFF_DIR, 32'(dv));
            bus(1'b1, `GPM_OFF_OUT, 32'(lfsr_q[14:10]));
            repeat (4) @(posedge clk);
            bus(1'b0, `GPM_OFF_IN, 32'h0);
            chk(rd, 32'(exp_in(dv, lfsr_q[14:10], lfsr_q[4:0])));
            chk(32'(gpio_pad.oe), 32'(dv));
        end
        // pulls alone decide undriven pins
        bus(1'b1, `GPM_OFF_DIR, 32'h0);
        ext_oe <= 5'h00;
        for (int i = 0; i < 4; i++) begin
            lfsr_q = lfsr_next(lfsr_q);
            dv = lfsr_q[4:0] | 5'h01;
            ev = ~lfsr_q[9:5] & dv;
            bus(1'b1, `GPM_OFF_PEN, 32'(dv));
            bus(1'b1, `GPM_OFF_PSEL, 32'(lfsr_q[9:5]));
            repeat (4) @(posedge clk);
            bus(1'b0, `GPM_OFF_IN, 32'h0);
            chk(rd & 32'(dv), 32'(lfsr_q[9:5] & dv));
            chk(32'(gpio_pad.pull_dn), 32'(ev));
        end
        $display("test pins done");
        // buffer fills while transmit is off, the extra byte is dropped
        {scan_tdo, scan_tdo_oe} <= 2'h3;
        bus(1'b1, `GPM_OFF_DIV, 32'h0000_0004);
        for (int i = 0; i < 64; i++) begin
            lfsr_q = lfsr_next(lfsr_q);
            sent_q.push_back(lfsr_q[7:0]);
            bus(1'b1, `GPM_OFF_DATA, 32'(lfsr_q[7:0]));
        end
        bus(1'b0, `GPM_OFF_STAT, 32'h0);
        chk(32'(rd[5]), 32'h0);
        bus(1'b1, `GPM_OFF_DATA, 32'h0000_005a);
        loop_en <= 1'b1;
        bus(1'b1, `GPM_OFF_FN, 32'h0000_0010);
        repeat (3) @(posedge clk);
        chk(32'({scan_tdi, tdo_pin_oe}), 32'h3);
        n = 0;
        do begin
            bus(1'b0, `GPM_OFF_STAT, 32'h0);
            n++;
        end while (rd[6] !== 1'b1 && n < 2000);
        if (n >= 2000) error_cnt++;
        repeat (20) @(posedge clk);
        foreach (sent_q[i]) begin
            repeat (2) @(posedge clk);
            bus(1'b0, `GPM_OFF_DATA, 32'h0);
            chk(rd, 32'(sent_q[i]));
        end
        bus(1'b0, `GPM_OFF_STAT, 32'h0);
        chk(32'(rd[1:0]), 32'h0);
        $display("test serial done");
        // serial off again: scan pins pass straight through
        bus(1'b1, `GPM_OFF_FN, 32'h0);
        loop_en <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            lfsr_q = lfsr_next(lfsr_q);
            {scan_tdo, scan_tdo_oe, ext_tdi} <= lfsr_q[2:0];
            repeat (5) @(posedge clk);
            chk(32'({tdo_pin_o, tdo_pin_oe, scan_tdi}), 32'({scan_tdo, scan_tdo_oe, ext_tdi}));
        end
        $display("test scan done");
        wrap_up();
    end
endmodule // tb_gpio_pin_function_mux
bind gpm_top gpm_props #(.NPIN(NPIN)) u_props (.*);
